/* File: logic/fmcc_cfg.svh */
// Offsets, field positions, reset values and pin timing for the flash controller
`ifndef FMCC_CFG_SVH
`define FMCC_CFG_SVH

// ==========================================================================
// Register byte offsets
`define FMCC_OFF_CMD 12'h000
`define FMCC_OFF_ADDR 12'h004
`define FMCC_OFF_WDATA 12'h008
`define FMCC_OFF_STATUS 12'h00c
`define FMCC_OFF_CODES 12'h010
`define FMCC_OFF_UADDR 12'h014
`define FMCC_OFF_RCODE 12'h018

// ==========================================================================
// Field positions
`define FMCC_ST_BUSY 0
`define FMCC_ST_AUTOSEL 1
`define FMCC_ST_EMBED 2
`define FMCC_ST_TEXC 3
`define FMCC_ST_RD_LSB 8
`define FMCC_TEXC_BIT 5
`define FMCC_ID_SECT_MSB 16
`define FMCC_ID_SECT_LSB 14

// ==========================================================================
// Reset values of the code registers
`define FMCC_RST_CODES 32'h0000_0000
`define FMCC_RST_UADDR 32'h0000_0000
`define FMCC_RST_RCODE 8'h00

// ==========================================================================
// Pin timing
`define FMCC_CLK_NS 25
`define FMCC_T_ACC_NS 120
`define FMCC_T_WE_NS 50
`define FMCC_SYNC_CYC 2
`define FMCC_WE_CYC ((`FMCC_T_WE_NS + `FMCC_CLK_NS - 1) / `FMCC_CLK_NS)
`define FMCC_RD_CYC (((`FMCC_T_ACC_NS + `FMCC_CLK_NS - 1) / `FMCC_CLK_NS) + `FMCC_SYNC_CYC)

`endif

/* File: logic/fmcc_pkg.sv */
// Types shared by the flash controller files
package fmcc_pkg;

    // ======================================================================
    // Operations and sequencer states
    typedef enum logic [2:0] {
        FMCC_OP_READ = 3'h0,
        FMCC_OP_WRITE = 3'h1,
        FMCC_OP_PROGRAM = 3'h2,
        FMCC_OP_AUTOSEL = 3'h3,
        FMCC_OP_RESET = 3'h4
    } fmcc_op_e;

    typedef enum logic [1:0] {
        FMCC_IDLE = 2'b00,
        FMCC_SETUP = 2'b01,
        FMCC_STROBE = 2'b11,
        FMCC_HOLD = 2'b10
    } fmcc_state_e;

    // ======================================================================
    // One bus cycle on the flash pins
    typedef struct packed {
        logic rd;
        logic last;
        logic [16:0] addr;
        logic [7:0] data;
    } fmcc_step_s;

    typedef struct packed {
        logic ce_n;
        logic oe_n;
        logic we_n;
    } fmcc_ctl_s;

endpackage : fmcc_pkg

/* File: logic/fmcc_sync.sv */
// Two-stage synchroniser for the data lines coming back from the flash
`timescale 1ns/10ps
module fmcc_sync #(
    parameter int WIDTH = 8
) (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);
    logic [WIDTH-1:0] meta;

    // ======================================================================
    // One pair of flip-flops per bit
    genvar b;
    generate
        for (b = 0; b < WIDTH; b++) begin : g_bit
            always_ff @(posedge i_clk) begin
                if (i_reset) begin
                    meta[b] <= 1'b0;
                    o_sync[b] <= 1'b0;
                end else begin
                    meta[b] <= i_async[b];
                    o_sync[b] <= meta[b];
                end
            end
        end
    endgenerate

endmodule : fmcc_sync

/* File: logic/fmcc_host.sv */
// Host-side controller driving a byte-wide parallel NOR flash over its strobe pins
// How it works
// [RL1] During program or erase, reads return status bits; plain reads fetch them.
// [RL2] Chip select high puts flash in standby; we idle with select high.
// [RL3] Deselecting mid-operation does not abort it; we deselect freely between cycles.
// [RL4] Output enable high floats flash outputs; we raise it except during reads.
// [RL5] Three top address bits choose one of eight 16 KB sectors.
// [RL6] Id reads set A6 low, A1/A0 low for maker, A0 high for device.
// [RL7] Protection verify places sector on top bits with A1 high, A0 low.
// [RL8] Autoselect mode yields maker, device and protection codes as readable values.
// [RL9] Autoselect is entered by writing unlock cycles then the autoselect command.
// [RL10] Protected sectors refuse program and erase until unprotected.
// [RL11] Sectors ship unprotected.
// [RL12] Below supply lockout the flash ignores writes and resets itself.
// [RL13] Writes start only with select and write strobe low, output enable high.
// [RL14] A write strobe held low at power-up is not taken as a command.
// [RL15] At power-up the flash reads array data without any command.
// [RL16] Program is preceded by the two unlock write cycles.
// [RL17] Wrong codes or order drop the sequence back to array read.
// [RL18] Address latched at the later fall, data at the earlier rise of strobes.
// [RL19] After an embedded operation the flash returns to array read by itself.
// [RL20] After timing exceeded shows, the reset command returns to array read.
// [RL21] Reset leaves autoselect; its address bits are ignored.
// [RL22] Reset aborts a partial sequence but is ignored once the operation runs.
//
// Added by the designer: the APB register port and the register addresses.
`timescale 1ns/10ps
`include "fmcc_cfg.svh"
module fmcc_host
    import fmcc_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    output logic [16:0] o_flash_addr,
    output logic [7:0] o_data_lines,
    output logic o_data_lines_oe_n,
    input wire logic [7:0] i_data_lines,
    output logic o_ce_n,
    output logic o_oe_n,
    output logic o_we_n
);
    localparam logic [3:0] WE_LAST = 4'(`FMCC_WE_CYC - 1);
    localparam logic [3:0] RD_LAST = 4'(`FMCC_RD_CYC - 1);

    fmcc_state_e state;
    fmcc_op_e op;
    fmcc_step_s step;
    fmcc_ctl_s ctl;
    logic [1:0] idx;
    logic [3:0] cnt;
    logic [16:0] addr;
    logic [7:0] wdata;
    logic [31:0] codes;
    logic [31:0] uaddr;
    logic [7:0] rcode;
    logic [7:0] rd_byte;
    logic [7:0] dq_sync;
    logic in_autosel;
    logic embed;
    logic texc;
    logic busy;
    logic wr_acc;
    logic rd_acc;
    logic start;
    logic mapped;
    logic done_pulse;
    logic sample;

    // ======================================================================
    // Pin input synchroniser
    fmcc_sync #(.WIDTH(8)) u_sync (
        .i_clk(i_clk),
        .i_reset(i_reset),
        .i_async(i_data_lines),
        .o_sync(dq_sync)
    );

    // ======================================================================
    // Sequence table: one entry per pin cycle of each operation
    function automatic fmcc_step_s step_of(input fmcc_op_e f_op, input logic [1:0] f_idx);
        fmcc_step_s s;
        logic [16:0] id_addr;
        s = '0;
        // Sector on the top bits, A6 low, A1/A0 choose the code
        id_addr = {addr[`FMCC_ID_SECT_MSB:`FMCC_ID_SECT_LSB], 7'h00, 1'b0, 4'h0, wdata[1:0]}; // see [RL5] [RL6] [RL7]
        case (f_op)
            FMCC_OP_PROGRAM, FMCC_OP_AUTOSEL: begin
                case (f_idx)
                    2'd0: s = '{rd: 1'b0, last: 1'b0, addr: {1'b0, uaddr[15:0]}, data: codes[7:0]}; // see [RL16] [RL9]
                    2'd1: s = '{rd: 1'b0, last: 1'b0, addr: {1'b0, uaddr[31:16]}, data: codes[15:8]};
                    2'd2: begin
                        s.addr = {1'b0, uaddr[15:0]};
                        s.data = (f_op == FMCC_OP_PROGRAM) ? codes[31:24] : codes[23:16];
                    end
                    default: begin
                        s.last = 1'b1;
                        s.rd = (f_op == FMCC_OP_AUTOSEL);
                        s.addr = (f_op == FMCC_OP_AUTOSEL) ? id_addr : addr; // see [RL8]
                        s.data = wdata;
                    end
                endcase
            end
            FMCC_OP_READ: s = '{rd: 1'b1, last: 1'b1, addr: addr, data: 8'h00}; // see [RL1] [RL15]
            FMCC_OP_RESET: s = '{rd: 1'b0, last: 1'b1, addr: addr, data: rcode}; // see [RL20] [RL21] [RL22]
            default: s = '{rd: 1'b0, last: 1'b1, addr: addr, data: wdata};
        endcase
        return s;
    endfunction : step_of

    always_comb begin
        step = step_of(op, idx);
    end

    // ======================================================================
    // APB slave: one wait state, error on unmapped offsets
    always_comb begin
        mapped = (i_paddr == `FMCC_OFF_CMD) || (i_paddr == `FMCC_OFF_ADDR) || (i_paddr == `FMCC_OFF_WDATA)
            || (i_paddr == `FMCC_OFF_STATUS) || (i_paddr == `FMCC_OFF_CODES) || (i_paddr == `FMCC_OFF_UADDR)
            || (i_paddr == `FMCC_OFF_RCODE);
        wr_acc = i_psel && i_penable && !o_pready && i_pwrite && mapped;
        rd_acc = i_psel && i_penable && !o_pready && !i_pwrite;
        busy = (state != FMCC_IDLE);
        // A command while busy is dropped; software polls busy first
        start = wr_acc && (i_paddr == `FMCC_OFF_CMD) && !busy && (i_pwdata[2:0] <= 3'(FMCC_OP_RESET));
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_pready <= 1'b0;
            o_pslverr <= 1'b0;
        end else begin
            o_pready <= i_psel && i_penable && !o_pready;
            o_pslverr <= i_psel && i_penable && !o_pready && !mapped;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_prdata <= 32'h0000_0000;
        end else if (rd_acc) begin
            case (i_paddr)
                `FMCC_OFF_ADDR: o_prdata <= {15'h0000, addr};
                `FMCC_OFF_WDATA: o_prdata <= {24'h000000, wdata};
                `FMCC_OFF_STATUS: o_prdata <= {16'h0000, rd_byte, 4'h0, texc, embed, in_autosel, busy};
                `FMCC_OFF_CODES: o_prdata <= codes;
                `FMCC_OFF_UADDR: o_prdata <= uaddr;
                `FMCC_OFF_RCODE: o_prdata <= {24'h000000, rcode};
                default: o_prdata <= 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            addr <= 17'h00000;
            wdata <= 8'h00;
            codes <= `FMCC_RST_CODES;
            uaddr <= `FMCC_RST_UADDR;
            rcode <= `FMCC_RST_RCODE;
        end else if (wr_acc && !busy) begin
            // Operands are frozen while a sequence runs on the pins
            case (i_paddr)
                `FMCC_OFF_ADDR: addr <= i_pwdata[16:0];
                `FMCC_OFF_WDATA: wdata <= i_pwdata[7:0];
                `FMCC_OFF_CODES: codes <= i_pwdata;
                `FMCC_OFF_UADDR: uaddr <= i_pwdata;
                `FMCC_OFF_RCODE: rcode <= i_pwdata[7:0];
                default: ;
            endcase
        end
    end

    // ======================================================================
    // Pin sequencer
    always_comb begin
        done_pulse = (state == FMCC_HOLD) && step.last;
        sample = (state == FMCC_STROBE) && step.rd && (cnt == RD_LAST);
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            state <= FMCC_IDLE;
            op <= FMCC_OP_READ;
            idx <= 2'd0;
            cnt <= 4'h0;
        end else begin
            case (state)
                FMCC_IDLE: begin
                    if (start) begin
                        op <= fmcc_op_e'(i_pwdata[2:0]);
                        idx <= 2'd0;
                        state <= FMCC_SETUP;
                    end
                end
                FMCC_SETUP: begin
                    cnt <= 4'h0;
                    state <= FMCC_STROBE;
                end
                FMCC_STROBE: begin
                    cnt <= cnt + 4'h1;
                    if (cnt == (step.rd ? RD_LAST : WE_LAST)) begin
                        state <= FMCC_HOLD;
                    end
                end
                FMCC_HOLD: begin
                    if (step.last) begin
                        state <= FMCC_IDLE;
                    end else begin
                        idx <= idx + 2'd1;
                        state <= FMCC_SETUP;
                    end
                end
                default: state <= FMCC_IDLE;
            endcase
        end
    end

    // Strobe levels per state; output enable stays high across every write
    always_comb begin
        ctl = '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1}; // see [RL2] [RL4]
        case (state)
            FMCC_SETUP: ctl = '{ce_n: 1'b0, oe_n: 1'b1, we_n: 1'b1};
            FMCC_STROBE: ctl = '{ce_n: 1'b0, oe_n: !step.rd, we_n: step.rd}; // see [RL13]
            default: ;
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_ce_n <= 1'b1;
            o_oe_n <= 1'b1;
            o_we_n <= 1'b1;
            o_flash_addr <= 17'h00000;
            o_data_lines <= 8'h00;
            o_data_lines_oe_n <= 1'b1;
        end else begin
            o_ce_n <= ctl.ce_n;
            o_oe_n <= ctl.oe_n;
            o_we_n <= ctl.we_n;
            // Address settles a cycle before the strobe falls, data holds past its rise
            if (state != FMCC_IDLE) begin
                o_flash_addr <= step.addr; // see [RL18]
                o_data_lines <= step.data;
            end
            o_data_lines_oe_n <= (state == FMCC_IDLE) || step.rd;
        end
    end

    // ======================================================================
    // Read capture and mode tracking
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            rd_byte <= 8'h00;
        end else if (sample) begin
            rd_byte <= dq_sync; // see [RL1]
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            in_autosel <= 1'b0;
            embed <= 1'b0;
        end else if (done_pulse) begin
            if (op == FMCC_OP_AUTOSEL) begin
                in_autosel <= 1'b1; // see [RL9]
            end else if (op == FMCC_OP_RESET) begin
                in_autosel <= 1'b0; // see [RL21]
                embed <= 1'b0;
            end
            if (op == FMCC_OP_PROGRAM) begin
                embed <= 1'b1;
            end
        end
    end

    // Sticky timing-exceeded seen in a status read; a reset command clears it, a new hit wins
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            texc <= 1'b0;
        end else if (sample && embed && dq_sync[`FMCC_TEXC_BIT]) begin
            texc <= 1'b1; // see [RL20]
        end else if (done_pulse && op == FMCC_OP_RESET) begin
            texc <= 1'b0;
        end
    end

    // ======================================================================
    // Checks
    a_write_oe_high: assert property (@(posedge i_clk) disable iff (i_reset) // see [RL13]
        !o_we_n |-> (o_oe_n && !o_ce_n && !o_data_lines_oe_n))
        else $error("write strobe low without select low and output enable high");

    a_addr_stable_we: assert property (@(posedge i_clk) disable iff (i_reset) // see [RL18]
        (!o_we_n && $past(!o_we_n)) |-> $stable(o_flash_addr) && $stable(o_data_lines))
        else $error("address or data moved during write strobe");

    a_data_held_rise: assert property (@(posedge i_clk) disable iff (i_reset) // see [RL18]
        $rose(o_we_n) |-> !o_data_lines_oe_n && $stable(o_data_lines))
        else $error("data released at write strobe rise");

    a_unlock_first: assert property (@(posedge i_clk) disable iff (i_reset) // see [RL16]
        (state == FMCC_SETUP && op == FMCC_OP_PROGRAM && idx == 2'd0)
        |=> o_flash_addr == {1'b0, uaddr[15:0]} && o_data_lines == codes[7:0])
        else $error("program did not open with the first unlock cycle");

    a_id_addr_bits: assert property (@(posedge i_clk) disable iff (i_reset) // see [RL6] [RL7]
        (state == FMCC_STROBE && op == FMCC_OP_AUTOSEL && idx == 2'd3)
        |-> !o_flash_addr[6] && o_flash_addr[1:0] == wdata[1:0])
        else $error("identifier read address bits wrong");

    a_autosel_enter: assert property (@(posedge i_clk) disable iff (i_reset) // see [RL9]
        (done_pulse && op == FMCC_OP_AUTOSEL) |=> in_autosel)
        else $error("autoselect mode not recorded");

    a_reset_exits: assert property (@(posedge i_clk) disable iff (i_reset) // see [RL21]
        (done_pulse && op == FMCC_OP_RESET) |=> (!in_autosel && !embed && !texc) ##1 (!texc || busy))
        else $error("reset command did not clear mode flags");

    a_texc_sticky: assert property (@(posedge i_clk) disable iff (i_reset) // see [RL20]
        (texc && !(done_pulse && op == FMCC_OP_RESET)) |=> texc)
        else $error("timing-exceeded flag dropped without reset command");

    a_read_len: assert property (@(posedge i_clk) disable iff (i_reset) // see [RL4]
        $fell(o_oe_n) |-> (!o_oe_n && !o_ce_n) [*7] ##1 o_oe_n)
        else $error("read strobe length wrong");

endmodule : fmcc_host

/* File: bench/fmcc_flash_model.sv */
// Behavioural byte-wide flash that answers the controller's strobe pins
`timescale 1ns/10ps
module fmcc_flash_model #(
    parameter logic [7:0] MAKER = 8'h3c, // Arbitrary value
    parameter logic [7:0] DEVID = 8'h5a, // Arbitrary value
    parameter logic [7:0] PROT = 8'h00,
    parameter int PROG_NS = 4000
) (
    input wire logic [16:0] i_addr,
    input wire logic [7:0] i_data,
    input wire logic i_ce_n,
    input wire logic i_oe_n,
    input wire logic i_we_n,
    output logic [7:0] o_q,
    output logic o_drive
);
    // ======================================================================
    // State: 0 array, 1/2 unlocked, 3 autoselect, 4 program setup, 5 busy, 6 failed
    logic [7:0] mem [0:131071];
    logic [2:0] st = 3'h0;
    logic [16:0] la = 17'h00000;
    logic [16:0] pa = 17'h00000;
    logic [7:0] pd = 8'h00;
    // No write is pending at power-up; supply is taken as always above lockout
    logic act = 1'b0;
    logic tog = 1'b0;
    event run;

    initial begin
        for (int i = 0; i < 131072; i++) begin
            mem[i] = 8'hff;
        end
    end

    task automatic take(input logic [16:0] a, input logic [7:0] d);
        logic u1;
        u1 = a[15:0] == 16'h0555;
        if (st >= 3'h5) begin
            if (st == 3'h6 && d == 8'hf0) st = 3'h0;
        end else if (d == 8'hf0) begin
            st = 3'h0;
        end else if (st == 3'h4) begin
            pa = a;
            pd = d;
            if (PROT[a[16:14]]) st = 3'h0;
            else if ((~mem[a] & d) != 8'h00) st = 3'h6;
            else st = 3'h5;
            if (st == 3'h5) -> run;
        end else if (st == 3'h1 && a[15:0] == 16'h02aa && d == 8'h55) begin
            st = 3'h2;
        end else if (st == 3'h2 && u1 && (d == 8'h90 || d == 8'ha0)) begin
            st = (d == 8'h90) ? 3'h3 : 3'h4;
        end else if (st != 3'h1 && st != 3'h2 && u1 && d == 8'haa) begin
            st = 3'h1;
        end else if (st != 3'h3) begin
            st = 3'h0;
        end
    endtask : take

    // ======================================================================
    // Write strobes
    always @(negedge i_we_n or negedge i_ce_n) begin
        if (!i_we_n && !i_ce_n && i_oe_n) begin
            la = i_addr;
            act = 1'b1;
        end
    end

    always @(posedge i_we_n or posedge i_ce_n) begin
        if (act) begin
            act = 1'b0;
            take(la, i_data);
        end
    end

    // Select is ignored here: deselecting never stops the operation
    always @(run) begin
        #(PROG_NS);
        mem[pa] = pd;
        st = 3'h0;
    end

    // ======================================================================
    // Read side
    always @(negedge i_oe_n) tog = ~tog;

    always @(i_addr or i_ce_n or i_oe_n or st or tog or pd) begin
        o_drive = !i_ce_n && !i_oe_n;
        if (st >= 3'h5) o_q = {~pd[7], tog, st == 3'h6, 5'h00};
        else if (st != 3'h3) o_q = mem[i_addr];
        else if (i_addr[1:0] == 2'h0) o_q = MAKER;
        else if (i_addr[1:0] == 2'h1) o_q = DEVID;
        else o_q = {7'h00, PROT[i_addr[16:14]]};
    end
endmodule : fmcc_flash_model

/* File: bench/flash_mode_and_command_control_test.sv */
// Self-checking bench for the flash controller against a behavioural flash
`timescale 1ns/10ps
`include "fmcc_cfg.svh"
module flash_mode_and_command_control_test
    import fmcc_pkg::*;
();
    localparam logic [7:0] MAKER_V = 8'h3c; // Arbitrary value
    localparam logic [7:0] DEVID_V = 8'h5a; // Arbitrary value
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata, q;
    logic pready, pslverr, err, doe_n, ce_n, oe_n, we_n, m_en;
    logic [16:0] fa;
    logic [7:0] dl, m_q, bus;
    logic [7:0] flt = 8'h00;
    int mismatches = 0;
    int n_tests = 0;
    int cyc = 0;
    logic [16:0] sel_a [4] = '{17'h00000, 17'h00000, 17'h14000, 17'h1c000};
    logic [7:0] sel_d [4] = '{8'h00, 8'h01, 8'h02, 8'h02};
    logic [7:0] sel_x [4] = '{MAKER_V, DEVID_V, 8'h01, 8'h00};

    initial begin
        forever #12.5 clk = ~clk;
    end

    fmcc_host DUT (
        .i_clk(clk), .i_reset(reset), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
        .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
        .o_flash_addr(fa), .o_data_lines(dl), .o_data_lines_oe_n(doe_n), .i_data_lines(bus),
        .o_ce_n(ce_n), .o_oe_n(oe_n), .o_we_n(we_n)
    );

    // Sectors five and six protected so that the refusal can be seen
    fmcc_flash_model #(.MAKER(MAKER_V), .DEVID(DEVID_V), .PROT(8'h60)) flash (
        .i_addr(fa), .i_data(bus), .i_ce_n(ce_n), .i_oe_n(oe_n), .i_we_n(we_n), .o_q(m_q), .o_drive(m_en)
    );

    // Released data lines show the inverse of the last driven byte, so a stale byte never reads as valid
    assign bus = !doe_n ? dl : (m_en ? m_q : flt);
    always @(posedge clk) begin
        if (!doe_n || m_en) flt <= ~bus;
    end

    // ======================================================================
    // Checking and closing
    task automatic print_verdict();
        $display("n_tests=%0d mismatches=%0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : print_verdict

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            mismatches++;
            print_verdict();
        end
    end

    always @(posedge clk) begin
        if (!reset && !we_n) chk({ce_n, oe_n, doe_n}, 3'b010);
        if (!reset && !oe_n) chk({ce_n, we_n, doe_n}, 3'b011);
    end

    // ======================================================================
    // Bus access
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb

    // Leaves the final status word in q
    task automatic op(input fmcc_op_e o, input logic [16:0] a, input logic [7:0] d);
        apb(1'b1, `FMCC_OFF_ADDR, {15'h0000, a});
        apb(1'b1, `FMCC_OFF_WDATA, {24'h000000, d});
        apb(1'b1, `FMCC_OFF_CMD, {29'h00000000, o});
        do apb(1'b0, `FMCC_OFF_STATUS, 32'h00000000); while (q[0] === 1'b1);
    endtask : op

    // ======================================================================
    // Main sequence
    initial begin
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        for (int i = 3; i < 7; i++) begin
            apb(1'b0, 12'(i * 4), 32'h00000000);
            chk(q, 32'h00000000);
            chk(err, 1'b0);
        end
        apb(1'b0, 12'h020, 32'h00000000);
        chk(err, 1'b1);
        chk(q, 32'h00000000);
        apb(1'b1, `FMCC_OFF_CODES, 32'ha090_55aa);
        apb(1'b1, `FMCC_OFF_UADDR, 32'h02aa_0555);
        apb(1'b1, `FMCC_OFF_RCODE, 32'h0000_00f0);
        op(FMCC_OP_READ, 17'h00123, 8'h00);
        chk(q[15:8], 8'hff);
        op(FMCC_OP_PROGRAM, 17'h04010, 8'h1c);
        op(FMCC_OP_READ, 17'h04010, 8'h00);
        chk({q[15], q[13], q[2]}, 3'b101);
        op(FMCC_OP_RESET, 17'h00000, 8'h00);
        op(FMCC_OP_READ, 17'h04010, 8'h00);
        chk(q[15], 1'b1);
        repeat (200) @(posedge clk);
        op(FMCC_OP_READ, 17'h04010, 8'h00);
        chk(q[15:8], 8'h1c);
        op(FMCC_OP_PROGRAM, 17'h14000, 8'h00);
        op(FMCC_OP_PROGRAM, 17'h13fff, 8'h00);
        repeat (200) @(posedge clk);
        op(FMCC_OP_READ, 17'h14000, 8'h00);
        chk(q[15:8], 8'hff);
        op(FMCC_OP_READ, 17'h13fff, 8'h00);
        chk(q[15:8], 8'h00);
        for (int i = 0; i < 4; i++) begin
            op(FMCC_OP_AUTOSEL, sel_a[i], sel_d[i]);
            chk({q[15:8], q[1]}, {sel_x[i], 1'b1});
        end
        apb(1'b1, `FMCC_OFF_CODES, 32'h7790_55aa);
        op(FMCC_OP_PROGRAM, 17'h04010, 8'h00);
        op(FMCC_OP_READ, 17'h04010, 8'h00);
        chk(q[15:8], 8'h1c);
        apb(1'b1, `FMCC_OFF_CODES, 32'ha090_55aa);
        op(FMCC_OP_AUTOSEL, 17'h00000, 8'h00);
        op(FMCC_OP_RESET, 17'h1abcd, 8'h00);
        op(FMCC_OP_READ, 17'h04010, 8'h00);
        chk({q[15:8], q[1]}, 9'h038);
        op(FMCC_OP_PROGRAM, 17'h04010, 8'hff);
        repeat (200) @(posedge clk);
        op(FMCC_OP_READ, 17'h04010, 8'h00);
        chk({q[13], q[3]}, 2'b11);
        op(FMCC_OP_RESET, 17'h00000, 8'h00);
        chk(q[3], 1'b0);
        op(FMCC_OP_READ, 17'h04010, 8'h00);
        chk(q[15:8], 8'h1c);
        print_verdict();
    end
endmodule : flash_mode_and_command_control_test
